//--- logic/smc_pkg.sv
package smc_pkg;

    // ****************************************************************
    // Core control register layout
    // ****************************************************************
    localparam logic [7:0] SMC_CTRL_ADDR     = 8'h35;
    localparam logic [7:0] SMC_STATUS_ADDR   = 8'h36;
    localparam int         SMC_BIT_BOD_OFF   = 7;
    localparam int         SMC_BIT_SE        = 5;
    localparam int         SMC_BIT_SM_HI     = 4;
    localparam int         SMC_BIT_SM_LO     = 3;
    localparam int         SMC_BIT_BOD_UNLK  = 2;
    localparam logic [7:0] SMC_CTRL_RST      = 8'h00;
    localparam logic [7:0] SMC_CTRL_WMASK    = 8'h7b;

    // ****************************************************************
    // Mode encodings and timing
    // ****************************************************************
    localparam logic [1:0] SMC_MODE_IDLE     = 2'h0;
    localparam logic [1:0] SMC_MODE_ADCNR    = 2'h1;
    localparam logic [1:0] SMC_MODE_PDOWN    = 2'h2;
    localparam int         SMC_WAKE_HALT_CYC = 4;
    localparam int         SMC_UNLOCK_CYC    = 4;
    localparam int         SMC_BROWNOUT_SLEEP_OFF_ACT_CYC  = 3;
    localparam int         SMC_BROWNOUT_SLEEP_OFF_LIFE_CYC = 3;
    localparam int         SMC_CLK_MHZ       = 50;
    localparam int         SMC_STARTUP_NS    = 1000;
    localparam int         SMC_RSTUP_NS      = 4000;
    localparam int         SMC_STARTUP_CYC   =
        (SMC_STARTUP_NS * SMC_CLK_MHZ + 999) / 1000;
    localparam int         SMC_RSTUP_CYC     =
        (SMC_RSTUP_NS * SMC_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        SMC_ST_RUN,
        SMC_ST_SLEEP,
        SMC_ST_START,
        SMC_ST_HALT
    } smc_state_t;

    typedef struct packed {
        logic ext_irq0_level;
        logic ext_irq0_edge;
        logic pin_change;
        logic self_program_ready;
        logic adc_done;
        logic other_io;
        logic wdt_irq;
    } smc_wake_t;

    typedef struct packed {
        logic cpu_clock;
        logic flash_clock;
        logic io_clock;
        logic adc_clock;
        logic main_osc;
    } smc_clk_en_t;

endpackage

//--- logic/smc_sleep_ctrl.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// Contract
// - Sleep entered only when sleep enable set and sleep instruction runs.
// - Mode 00 idle stops CPU and flash clocks only.
// - Mode 01 noise reduction also stops the I/O clock.
// - Mode 10 power-down stops the oscillator and every generated clock.
// - Wake by interrupt holds core four cycles after clock start-up.
// - Sleep never alters register file or static RAM contents.
// - Reset during sleep wakes device and restarts at reset vector.
// - Idle wakes on any enabled interrupt source.
// - Noise reduction wakes on ADC, resets, SELF_PROGRAM_READY, level irq0, pin, watchdog.
// - Power-down wakes on resets, level irq0, pin change, watchdog.
// - In deeper modes only level irq0 wakes, edges do not.
// - ADC enabled on idle or noise-reduction entry starts a conversion.
// - Brown-out sleep-off is bit 7 of control, resets zero.
// - Detector off right after sleep entry, back on at wake; the code turns it off only in power-down.
// - Wake after detector-off sleep uses the reset start-up delay.
// - Off bit needs unlock write then off-only write within four cycles.
// - Off bit active three cycles after set, self-clears three later.
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int STARTUP_CYC = SMC_STARTUP_CYC,
    parameter int RSTUP_CYC   = SMC_RSTUP_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_sleep_instr,
    input  wire smc_wake_t   i_wake,
    input  wire logic        i_sys_reset,
    input  wire logic        i_adc_enabled,
    output smc_clk_en_t      o_clk_en,
    output logic             o_core_halt,
    output logic             o_irq_service,
    output logic             o_adc_start,
    output logic             o_brownout_detector_en
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic             rst_s1_r;
    logic             rst_s2_r;
    logic             rst_n;
    smc_wake_t        wake_s1_r;
    smc_wake_t        wake_r;
    logic             sysrst_s1_r;
    logic             sysrst_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // Wake sources come from other domains and from asynchronous pins.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_r   <= '0;
            wake_r      <= '0;
            sysrst_s1_r <= 1'b0;
            sysrst_r    <= 1'b0;
        end else begin
            wake_s1_r   <= i_wake;
            wake_r      <= wake_s1_r;
            sysrst_s1_r <= i_sys_reset;
            sysrst_r    <= sysrst_s1_r;
        end
    end

    // ****************************************************************
    // Core control register
    // ****************************************************************
    logic [7:0]       ctrl_r;
    logic [2:0]       unlock_cnt_r;
    logic [2:0]       brownout_sleep_off_cnt_r;
    logic             brownout_sleep_off_set_r;
    logic             ctrl_wr;
    logic             unlock_wr;
    logic             off_wr;
    logic             brownout_sleep_off_active;

    assign ctrl_wr   = i_wr && (i_addr == SMC_CTRL_ADDR);
    assign unlock_wr = ctrl_wr && i_wdata[SMC_BIT_BOD_OFF]
                       && i_wdata[SMC_BIT_BOD_UNLK];
    assign off_wr    = ctrl_wr && i_wdata[SMC_BIT_BOD_OFF]
                       && !i_wdata[SMC_BIT_BOD_UNLK]
                       && (unlock_cnt_r != 3'h0);

    // Sleep enable, mode and ordinary bits; the off bit is timed apart.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= SMC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= i_wdata & SMC_CTRL_WMASK;
        end
    end

    // Unlock window stays open for a fixed count after the unlock write.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_cnt_r <= 3'h0;
        end else if (unlock_wr) begin
            unlock_cnt_r <= 3'(SMC_UNLOCK_CYC);
        end else if (unlock_cnt_r != 3'h0) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
    end

    // Off bit: counts activation delay, then a short active life.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_sleep_off_set_r <= 1'b0;
            brownout_sleep_off_cnt_r <= 3'h0;
        end else if (off_wr) begin
            brownout_sleep_off_set_r <= 1'b1;
            brownout_sleep_off_cnt_r <= 3'(SMC_BROWNOUT_SLEEP_OFF_ACT_CYC + SMC_BROWNOUT_SLEEP_OFF_LIFE_CYC);
        end else if (brownout_sleep_off_cnt_r != 3'h0) begin
            brownout_sleep_off_cnt_r <= brownout_sleep_off_cnt_r - 3'h1;
        end else begin
            brownout_sleep_off_set_r <= 1'b0;
        end
    end
    assign brownout_sleep_off_active = brownout_sleep_off_set_r
        && (brownout_sleep_off_cnt_r <= 3'(SMC_BROWNOUT_SLEEP_OFF_LIFE_CYC))
        && (brownout_sleep_off_cnt_r != 3'h0);

    // ****************************************************************
    // Sleep sequencer
    // ****************************************************************
    smc_state_t       state_r;
    logic [1:0]       mode_r;
    logic             bod_off_r;
    logic [31:0]      cnt_r;
    logic             wake_irq;
    logic             enter;

    assign enter = i_sleep_instr && ctrl_r[SMC_BIT_SE]
        && (ctrl_r[SMC_BIT_SM_HI:SMC_BIT_SM_LO] != 2'h3);

    always_comb begin
        wake_irq = 1'b0;
        unique case (mode_r)
            SMC_MODE_IDLE:  wake_irq = |wake_r;
            SMC_MODE_ADCNR: wake_irq = wake_r.adc_done
                || wake_r.self_program_ready || wake_r.ext_irq0_level
                || wake_r.pin_change || wake_r.wdt_irq;
            SMC_MODE_PDOWN: wake_irq = wake_r.ext_irq0_level
                || wake_r.pin_change || wake_r.wdt_irq;
            default:        wake_irq = 1'b0;
        endcase
    end

    // A level source that drops before HALT ends is still serviced; the
    // source need only hold it until the wake is seen in SLEEP.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= SMC_ST_RUN;
            mode_r    <= SMC_MODE_IDLE;
            bod_off_r <= 1'b0;
            cnt_r     <= 32'h0;
        end else if (sysrst_r) begin
            state_r   <= SMC_ST_RUN;
            bod_off_r <= 1'b0;
            cnt_r     <= 32'h0;
        end else begin
            unique case (state_r)
                SMC_ST_RUN: begin
                    if (enter) begin
                        state_r   <= SMC_ST_SLEEP;
                        mode_r    <= ctrl_r[SMC_BIT_SM_HI:SMC_BIT_SM_LO];
                        bod_off_r <= brownout_sleep_off_active && (ctrl_r[SMC_BIT_SM_HI:
                            SMC_BIT_SM_LO] == SMC_MODE_PDOWN);
                    end
                end
                SMC_ST_SLEEP: begin
                    if (wake_irq) begin
                        state_r   <= SMC_ST_START;
                        bod_off_r <= 1'b0;
                        cnt_r <= bod_off_r ? 32'(RSTUP_CYC)
                                           : 32'(STARTUP_CYC);
                    end
                end
                SMC_ST_START: begin
                    if (cnt_r <= 32'h1) begin
                        state_r <= SMC_ST_HALT;
                        cnt_r   <= 32'(SMC_WAKE_HALT_CYC);
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                SMC_ST_HALT: begin
                    if (cnt_r <= 32'h1) begin
                        state_r <= SMC_ST_RUN;
                        cnt_r   <= 32'h0;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Outputs; CPU and flash clocks are off only in SLEEP and START; reset turns every clock on.
    // ****************************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_clk_en <= '1;
        end else begin
            o_clk_en <= '1;
            if (state_r == SMC_ST_SLEEP) begin
                o_clk_en.cpu_clock   <= 1'b0;
                o_clk_en.flash_clock <= 1'b0;
                o_clk_en.io_clock    <= (mode_r == SMC_MODE_IDLE);
                o_clk_en.adc_clock   <= (mode_r != SMC_MODE_PDOWN);
                o_clk_en.main_osc    <= (mode_r != SMC_MODE_PDOWN);
            end else if (state_r == SMC_ST_START) begin
                o_clk_en.cpu_clock   <= 1'b0;
                o_clk_en.flash_clock <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_core_halt            <= 1'b0;
            o_irq_service          <= 1'b0;
            o_adc_start            <= 1'b0;
            o_brownout_detector_en <= 1'b1;
        end else begin
            o_core_halt   <= (state_r != SMC_ST_RUN)
                             || (enter && !sysrst_r);
            o_irq_service <= (state_r == SMC_ST_HALT) && (cnt_r <= 32'h1)
                             && !sysrst_r;
            o_adc_start   <= enter && !sysrst_r && i_adc_enabled
                && (ctrl_r[SMC_BIT_SM_HI:SMC_BIT_SM_LO]
                    != SMC_MODE_PDOWN);
            o_brownout_detector_en <= !(bod_off_r
                && (state_r == SMC_ST_SLEEP));
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd && i_addr == SMC_CTRL_ADDR) begin
            o_rdata <= ctrl_r | {brownout_sleep_off_active, 7'h00};
        end else if (i_rd && i_addr == SMC_STATUS_ADDR) begin
            o_rdata <= {5'h00, bod_off_r, (state_r != SMC_ST_RUN),
                        unlock_cnt_r != 3'h0};
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // smc_sleep_ctrl

//--- testbench/smc_sleep_ctrl_properties.sv
`timescale 1ns/1ps
module smc_sleep_ctrl_properties
    import smc_pkg::*;
#(
    parameter int STARTUP_CYC = SMC_STARTUP_CYC,
    parameter int RSTUP_CYC   = SMC_RSTUP_CYC
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        i_sleep_instr,
    input wire smc_wake_t   i_wake,
    input wire logic        i_sys_reset,
    input wire logic        i_adc_enabled,
    input wire smc_clk_en_t o_clk_en,
    input wire logic        o_core_halt,
    input wire logic        o_irq_service,
    input wire logic        o_adc_start,
    input wire logic        o_brownout_detector_en
);
    localparam int SvcLag = STARTUP_CYC + SMC_WAKE_HALT_CYC;
    logic [7:0] ctl_r;
    logic [1:0] mode;
    // Shadow of the stored control bits; bit 7 never stores directly.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_r <= SMC_CTRL_RST;
        end else if (i_wr && i_addr == SMC_CTRL_ADDR) begin
            ctl_r <= i_wdata & SMC_CTRL_WMASK;
        end
    end
    assign mode = ctl_r[SMC_BIT_SM_HI:SMC_BIT_SM_LO];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_sleep_entry: assert property (i_sleep_instr && ctl_r[5] &&
        mode != 2'h3 && !o_core_halt && !i_sys_reset |=> o_core_halt)
        else $error("sleep not entered");
    a_no_enable: assert property (i_sleep_instr && !ctl_r[5] &&
        !o_core_halt |=> !o_core_halt) else $error("slept without enable");
    a_idle_clocks: assert property ($rose(o_core_halt) &&
        mode == SMC_MODE_IDLE |=> o_clk_en == 5'h07)
        else $error("idle clock gating wrong");
    a_quiet_clocks: assert property ($rose(o_core_halt) &&
        mode == SMC_MODE_ADCNR |=> o_clk_en == 5'h03)
        else $error("noise reduction clock gating wrong");
    a_pdown_clocks: assert property ($rose(o_core_halt) &&
        mode == SMC_MODE_PDOWN |=> o_clk_en == 5'h00)
        else $error("power-down clock gating wrong");
    a_wake_halt: assert property (o_irq_service |->
        $past(o_core_halt) && $past(o_core_halt, SvcLag))
        else $error("service without full halt");
    a_svc_bod_on: assert property (o_irq_service |->
        o_brownout_detector_en) else $error("detector off at wake");
    a_bod_off_pd: assert property (!o_brownout_detector_en |->
        o_core_halt && o_clk_en == 5'h00)
        else $error("detector off outside power-down");
    a_adc_entry: assert property ($rose(o_core_halt) |->
        o_adc_start == ($past(i_adc_enabled) && mode != SMC_MODE_PDOWN))
        else $error("conversion start wrong on entry");
    cover property (o_irq_service);
    cover property (!o_brownout_detector_en);
    cover property (o_adc_start && mode == SMC_MODE_ADCNR);
endmodule // smc_sleep_ctrl_properties

bind smc_sleep_ctrl smc_sleep_ctrl_properties #(
    .STARTUP_CYC(STARTUP_CYC),
    .RSTUP_CYC  (RSTUP_CYC)
) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sleep_instr(i_sleep_instr), .i_wake(i_wake),
    .i_sys_reset(i_sys_reset), .i_adc_enabled(i_adc_enabled),
    .o_clk_en(o_clk_en), .o_core_halt(o_core_halt),
    .o_irq_service(o_irq_service), .o_adc_start(o_adc_start),
    .o_brownout_detector_en(o_brownout_detector_en)
);

//--- testbench/smc_core_model.sv
`timescale 1ns/1ps
module smc_core_model
    import smc_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_go,
    input  wire smc_wake_t i_src,
    input  wire logic      i_clr,
    input  wire logic      i_svc,
    output logic           o_sleep,
    output smc_wake_t      o_wake,
    output int             o_lat
);
    int cnt_r;
    initial o_wake = '0;
    initial o_sleep = 1'b0;
    // Sources keep their level until the core enters the service routine or a system reset,
    // since a level wake that drops early may never be seen.
    always @(posedge i_clk) begin
        if (i_svc || i_clr) begin
            o_wake <= '0;
        end else begin
            o_wake <= o_wake | i_src;
        end
        o_sleep <= i_go;
        cnt_r <= (o_wake != '0) ? cnt_r + 1 : 0;
        if (i_svc) begin
            o_lat <= cnt_r;
        end
    end
endmodule // smc_core_model

//--- testbench/smc_sleep_ctrl_tb_top.sv
`timescale 1ns/1ps
module smc_sleep_ctrl_tb_top;
    import smc_pkg::*;
    localparam int SU = 3;
    localparam int RU = 6;
    logic        i_clk, i_rst_n, i_wr, i_rd, go, clr, adc_en;
    logic        halt, svc, adc_st, bod_en, sleep;
    logic [1:0]  m;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    smc_wake_t   src, wake;
    smc_clk_en_t clk_en;
    int          lat, l0, n_adc, n_svc, i, error_cnt, total_checks;
    // Columns: mode, wake source, ADC enabled, wake expected.
    logic [10:0] rows [12] = '{11'h00b, 11'h081, 11'h213, 11'h208,
        11'h280, 11'h221, 11'h301, 11'h503, 11'h441, 11'h405, 11'h420,
        11'h480};

    smc_sleep_ctrl #(.STARTUP_CYC(SU), .RSTUP_CYC(RU)) DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sleep_instr(sleep), .i_wake(wake), .i_sys_reset(clr),
        .i_adc_enabled(adc_en), .o_clk_en(clk_en), .o_core_halt(halt),
        .o_irq_service(svc), .o_adc_start(adc_st),
        .o_brownout_detector_en(bod_en));
    smc_core_model u_core (.i_clk(i_clk), .i_go(go), .i_src(src),
        .i_clr(clr), .i_svc(svc), .o_sleep(sleep), .o_wake(wake),
        .o_lat(lat));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        n_adc += adc_st;
        n_svc += svc;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", e, o_rdata);
    endtask
    task automatic doze(input logic [7:0] c, input logic a, input int g);
        @(posedge i_clk);
        adc_en <= a;
        wr(SMC_CTRL_ADDR, c);
        repeat (g) @(posedge i_clk);
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    // A refused wake is ended by a system reset so each row starts awake.
    task automatic rouse(input smc_wake_t s, input logic ok);
        int k;
        n_svc = 0;
        @(posedge i_clk);
        src <= s;
        @(posedge i_clk);
        src <= '0;
        for (k = 0; k < 40 && n_svc == 0; k++) @(posedge i_clk);
        if (!ok) begin
            clr <= 1'b1;
            repeat (4) @(posedge i_clk);
            clr <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        #1 chk("service", {7'h0, ok}, 8'(n_svc));
        chk("halt", 8'h00, {7'h0, halt});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        test_done();
    end

    initial begin
        {i_rst_n, i_wr, i_rd, go, clr, adc_en} = 6'h00;
        {i_addr, i_wdata, src} = '0;
        error_cnt = 0;
        total_checks = 0;
        n_adc = 0;
        n_svc = 0;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        for (i = 0; i < 12; i++) begin
            m = rows[i][10:9];
            n_adc = 0;
            doze({2'h0, 1'b1, m, 3'h0}, rows[i][1], 0);
            chk("clk_en", {3'h0, (m == 2'h0) ? 5'h07 :
                (m == 2'h1) ? 5'h03 : 5'h00}, {3'h0, clk_en});
            chk("adc_start", {7'h0, rows[i][1] && m != 2'h2}, 8'(n_adc));
            rouse(rows[i][8:2], rows[i][0]);
            $display("row %0d done", i);
        end
        doze(8'h30, 1'b0, 0);
        rouse(7'h10, 1'b1);
        l0 = lat;
        chk("halt_span", 8'h01, {7'h0, l0 >= SU + SMC_WAKE_HALT_CYC});
        wr(SMC_CTRL_ADDR, 8'h84);
        doze(8'hb0, 1'b0, 2);
        chk("bod_off", 8'h00, {7'h0, bod_en});
        rouse(7'h10, 1'b1);
        chk("wake_delay", 8'(RU - SU), 8'(lat - l0));
        wr(SMC_CTRL_ADDR, 8'h84);
        repeat (4) @(posedge i_clk);
        doze(8'hb0, 1'b0, 2);
        chk("bod_late", 8'h01, {7'h0, bod_en});
        rouse(7'h10, 1'b1);
        wr(SMC_CTRL_ADDR, 8'h84);
        doze(8'hb0, 1'b0, 8);
        chk("bod_expired", 8'h01, {7'h0, bod_en});
        rouse(7'h10, 1'b1);
        $display("detector tests done");
        doze(8'h10, 1'b0, 0);
        chk("no_sleep", 8'h1f, {2'h0, halt, clk_en});
        wr(SMC_CTRL_ADDR, 8'hff);
        rd(SMC_STATUS_ADDR, 8'h01);
        rd(SMC_CTRL_ADDR, 8'h7b);
        rd(8'h00, 8'h00);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk("reset_out", 8'h5f, {1'b0, bod_en, halt, clk_en});
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(SMC_CTRL_ADDR, 8'h00);
        $display("register and reset tests done");
        test_done();
    end
endmodule // smc_sleep_ctrl_tb_top
